// File: aqis_top.sv
`timescale 1ns/100ps
`include "aqis_defines.svh"
// Notes on behaviour
// - quiet request falling edge starts quiet, clears alarm
// - quiet mode lasts 368 oscillator cycles
// - reduced-sensitivity output low during quiet strobes
// - quiet expiry gives two 10 ms chirps
// - quiet mode flashes indicator about every 10 s
// - smoke at reduced level still alarms in quiet
// - alarm never stops or restarts quiet timer
// - local alarm drives interconnect after 3 s
// - remote high switches oscillator to fast period
// - remote accepted after current plus two cycles
// - interconnect drop during qualification clears pending latch
// - remote-only alarm keeps indicator off
// - local alarm ignores interconnect as input
// - remote alarm still works during quiet mode
// - battery compared every 40 s during indicator pulse
// - power-up clears every internal counter
// - test mode drives sounder on low battery
// - strobe stays 10 ms under accelerated clock
// - standby 1.67 s cycle with 10 ms check
// - indicator and battery check every 24 cycles
// - alarm horn 160 ms on, 80 ms off
// - smoke suppresses battery warning, indicator each second
module aqis_top
  import aqis_pkg::*;
#(
  parameter int unsigned SLOW_CYC = `AQIS_US2CYC(`AQIS_SLOW_US),
  parameter int unsigned FAST_CYC = `AQIS_US2CYC(`AQIS_FAST_US),
  parameter int unsigned STROBE_CYC = `AQIS_US2CYC(`AQIS_STROBE_US)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic smokeDetected,
  input wire logic batteryLow,
  input wire logic quietRequest,
  input wire logic interconnectIn,
  input wire logic timing_capacitor_node,
  input wire logic sounder_in_a,
  input wire logic extOscSelect,
  output logic sounder_drive_a,
  output logic indicatorOn,
  output logic interconnectOut,
  output logic interconnectOe_n,
  output logic reducedSensOut,
  output logic reducedSensOe_n,
  output logic sensePower,
  output logic batteryCheck,
  output aqis_pkg::aqis_alarm_t alarmState
);
  import aqis_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [`AQIS_IN_WIDTH-1:0] pinRaw;
  logic [`AQIS_IN_WIDTH-1:0] pinSync;

  assign pinRaw = {extOscSelect, sounder_in_a, timing_capacitor_node, interconnectIn,
                   quietRequest, batteryLow, smokeDetected};

  aqis_sync #(.WIDTH(`AQIS_IN_WIDTH)) uSync (
    .clk(clk),
    .rst(rst),
    .async(pinRaw),
    .synced(pinSync)
  );

  logic smokeLvl;
  logic batLowLvl;
  logic quietLvl;
  logic ioLvl;
  logic capLvl;
  logic extOsc;
  assign smokeLvl = pinSync[`AQIS_IN_SMOKE];
  assign batLowLvl = pinSync[`AQIS_IN_BATLOW];
  assign quietLvl = pinSync[`AQIS_IN_QUIET];
  assign ioLvl = pinSync[`AQIS_IN_IO];
  assign capLvl = pinSync[`AQIS_IN_CAP];
  assign extOsc = pinSync[`AQIS_IN_EXTOSC];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aqis_cyc_t cycCnt_q, cycCnt_d;
  aqis_strobe_t strobeCnt_q, strobeCnt_d;
  aqis_strobe_t pulseCnt_q, pulseCnt_d;
  logic capPrev_q, capPrev_d;
  logic quietPrev_q, quietPrev_d;
  logic ioPrev_q, ioPrev_d;
  logic quietActive_q, quietActive_d;
  logic [8:0] quietCnt_q, quietCnt_d;
  logic chirpLeft_q, chirpLeft_d;
  logic [4:0] ledCnt_q, ledCnt_d;
  logic [2:0] hornPhase_q, hornPhase_d;
  logic [6:0] ioDelay_q, ioDelay_d;
  logic pending_q, pending_d;
  logic [1:0] qualCnt_q, qualCnt_d;
  aqis_alarm_t alarm_q, alarm_d;
  logic ledFlag_q, ledFlag_d;
  logic chirpFlag_q, chirpFlag_d;
  logic batFlag_q, batFlag_d;
  logic [1:0] startCnt_q, startCnt_d;
  logic testMode_q, testMode_d;
  logic sounder_d, indicator_d, ioOut_d, ioOeN_d, redOeN_d, sense_d, batChk_d;

  logic fastMode;
  logic tick;
  logic quietFall;
  logic ioRise;
  logic strobeEnd;
  logic [4:0] ledLimit;
  logic hornSounding;

  // ---------------------------------------------------------------
  // time base and sequencing
  // ---------------------------------------------------------------
  always_comb begin
    // an interconnect level alone speeds the clock up before qualification
    fastMode = (alarm_q != AL_IDLE) || pending_q || ioLvl;
    cycCnt_d = cycCnt_q + 27'd1;
    tick = 1'b0;
    if (extOsc) begin
      cycCnt_d = '0;
      tick = capLvl && !capPrev_q;
    end else if (cycCnt_q >= (fastMode ? 27'(FAST_CYC - 1) : 27'(SLOW_CYC - 1))) begin
      cycCnt_d = '0;
      tick = 1'b1;
    end
    capPrev_d = capLvl;

    quietPrev_d = tick ? quietLvl : quietPrev_q;
    ioPrev_d = tick ? ioLvl : ioPrev_q;
    quietFall = tick && quietPrev_q && !quietLvl;
    ioRise = tick && !ioPrev_q && ioLvl;
    strobeEnd = (strobeCnt_q == 19'd1);

    alarm_d = alarm_q;
    quietActive_d = quietActive_q;
    quietCnt_d = quietCnt_q;
    chirpLeft_d = chirpLeft_q;
    ledCnt_d = ledCnt_q;
    hornPhase_d = hornPhase_q;
    ioDelay_d = ioDelay_q;
    pending_d = pending_q;
    qualCnt_d = qualCnt_q;
    ledFlag_d = ledFlag_q;
    chirpFlag_d = chirpFlag_q;
    batFlag_d = batFlag_q;
    // strobe length is counted on clk, never on the tick source
    strobeCnt_d = (strobeCnt_q != '0) ? strobeCnt_q - 19'd1 : '0;
    pulseCnt_d = (pulseCnt_q != '0) ? pulseCnt_q - 19'd1 : '0;

    if (alarm_q == AL_LOCAL) begin
      ledLimit = 5'(`AQIS_ALARM_LED_TICKS);
    end else if (quietActive_q) begin
      ledLimit = 5'(`AQIS_QUIET_LED_TICKS);
    end else begin
      ledLimit = 5'(`AQIS_BAT_TICKS);
    end

    if (tick) begin
      // quiet timer keeps running whatever the alarm state does
      if (quietActive_q) begin
        if (quietCnt_q == 9'(`AQIS_QUIET_TICKS - 1)) begin
          quietActive_d = 1'b0;
          quietCnt_d = '0;
          chirpLeft_d = 1'b1;
        end else begin
          quietCnt_d = quietCnt_q + 9'd1;
        end
      end
      chirpFlag_d = (quietActive_q && quietCnt_q == 9'(`AQIS_QUIET_TICKS - 1)) || chirpLeft_q;
      if (chirpLeft_q) begin
        chirpLeft_d = 1'b0;
      end
      if (ledCnt_q >= ledLimit - 5'd1) begin
        ledCnt_d = '0;
        ledFlag_d = (alarm_q != AL_REMOTE);
        batFlag_d = (alarm_q == AL_IDLE) && !quietActive_q;
      end else begin
        ledCnt_d = ledCnt_q + 5'd1;
        ledFlag_d = 1'b0;
        batFlag_d = 1'b0;
      end
      pulseCnt_d = 19'(STROBE_CYC);
      if (alarm_q == AL_IDLE) begin
        hornPhase_d = '0;
        strobeCnt_d = (strobeCnt_q == '0) ? 19'(STROBE_CYC) : strobeCnt_d;
      end else begin
        hornPhase_d = (hornPhase_q == 3'(`AQIS_HORN_ON_TICKS + `AQIS_HORN_OFF_TICKS - 1)) ? 3'd0
                      : hornPhase_q + 3'd1;
        if (hornPhase_q >= 3'(`AQIS_HORN_ON_TICKS) && strobeCnt_q == '0) begin
          strobeCnt_d = 19'(STROBE_CYC);
        end
      end
      if (alarm_q == AL_LOCAL && ioDelay_q != 7'(`AQIS_IO_DELAY_TICKS)) begin
        ioDelay_d = ioDelay_q + 7'd1;
      end
      if (pending_q) begin
        if (qualCnt_q == 2'(`AQIS_QUAL_TICKS - 1)) begin
          pending_d = 1'b0;
          alarm_d = ioLvl ? AL_REMOTE : alarm_d;
        end else begin
          qualCnt_d = qualCnt_q + 2'd1;
        end
      end else if (alarm_q == AL_REMOTE && !ioLvl) begin
        alarm_d = AL_IDLE;
      end
    end

    if (alarm_q != AL_LOCAL) begin
      ioDelay_d = '0;
    end

    // qualification latch; a local alarm owns the line
    if (alarm_q == AL_LOCAL) begin
      pending_d = 1'b0;
      qualCnt_d = '0;
    end else if (pending_q && !ioLvl) begin
      pending_d = 1'b0;
      qualCnt_d = '0;
    end else if (!pending_q && alarm_q == AL_IDLE && ioRise) begin
      pending_d = 1'b1;
      qualCnt_d = '0;
    end

    // smoke result is taken at the last strobe cycle
    if (strobeEnd) begin
      if (smokeLvl) begin
        alarm_d = AL_LOCAL;
      end else if (alarm_q == AL_LOCAL) begin
        alarm_d = AL_IDLE;
      end
    end

    if (quietFall) begin
      quietActive_d = 1'b1;
      quietCnt_d = '0;
      alarm_d = AL_IDLE;
      pending_d = 1'b0;
      qualCnt_d = '0;
    end

    // test-mode strap (sounder_in_a and capacitor node both low) is taken once the synchronisers have filled
    startCnt_d = (startCnt_q == 2'd3) ? startCnt_q : startCnt_q + 2'd1;
    testMode_d = testMode_q;
    if (startCnt_q == 2'd2) begin
      testMode_d = !pinSync[`AQIS_IN_SNDR] && !capLvl;
    end

    hornSounding = (alarm_q != AL_IDLE) && (hornPhase_q < 3'(`AQIS_HORN_ON_TICKS));
    if (testMode_q) begin
      sounder_d = batLowLvl;
    end else begin
      sounder_d = hornSounding || ((pulseCnt_q != '0) && (chirpFlag_q || (batFlag_q && batLowLvl)));
    end
    indicator_d = (pulseCnt_q != '0) && ledFlag_q && (alarm_q != AL_REMOTE);
    batChk_d = (pulseCnt_q != '0) && batFlag_q && (alarm_q == AL_IDLE);
    sense_d = (strobeCnt_q != '0);
    redOeN_d = !(quietActive_q && strobeCnt_q != '0);
    ioOut_d = (alarm_q == AL_LOCAL) && (ioDelay_q == 7'(`AQIS_IO_DELAY_TICKS));
    ioOeN_d = !ioOut_d;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cycCnt_q <= '0;
      strobeCnt_q <= '0;
      pulseCnt_q <= '0;
      capPrev_q <= 1'b0;
      quietPrev_q <= 1'b0;
      ioPrev_q <= 1'b0;
      quietActive_q <= 1'b0;
      quietCnt_q <= '0;
      chirpLeft_q <= 1'b0;
      ledCnt_q <= '0;
      hornPhase_q <= '0;
      ioDelay_q <= '0;
      pending_q <= 1'b0;
      qualCnt_q <= '0;
      alarm_q <= AL_IDLE;
      ledFlag_q <= 1'b0;
      chirpFlag_q <= 1'b0;
      batFlag_q <= 1'b0;
      startCnt_q <= '0;
      testMode_q <= 1'b0;
      sounder_drive_a <= 1'b0;
      indicatorOn <= 1'b0;
      interconnectOut <= 1'b0;
      interconnectOe_n <= 1'b1;
      reducedSensOut <= 1'b0;
      reducedSensOe_n <= 1'b1;
      sensePower <= 1'b0;
      batteryCheck <= 1'b0;
      alarmState <= AL_IDLE;
    end else begin
      cycCnt_q <= cycCnt_d;
      strobeCnt_q <= strobeCnt_d;
      pulseCnt_q <= pulseCnt_d;
      capPrev_q <= capPrev_d;
      quietPrev_q <= quietPrev_d;
      ioPrev_q <= ioPrev_d;
      quietActive_q <= quietActive_d;
      quietCnt_q <= quietCnt_d;
      chirpLeft_q <= chirpLeft_d;
      ledCnt_q <= ledCnt_d;
      hornPhase_q <= hornPhase_d;
      ioDelay_q <= ioDelay_d;
      pending_q <= pending_d;
      qualCnt_q <= qualCnt_d;
      alarm_q <= alarm_d;
      ledFlag_q <= ledFlag_d;
      chirpFlag_q <= chirpFlag_d;
      batFlag_q <= batFlag_d;
      startCnt_q <= startCnt_d;
      testMode_q <= testMode_d;
      sounder_drive_a <= sounder_d;
      indicatorOn <= indicator_d;
      interconnectOut <= ioOut_d;
      interconnectOe_n <= ioOeN_d;
      reducedSensOut <= 1'b0;
      reducedSensOe_n <= redOeN_d;
      sensePower <= sense_d;
      batteryCheck <= batChk_d;
      alarmState <= alarm_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_quiet_entry: assert property (@(posedge clk) disable iff (rst)
    quietFall |=> quietActive_q && quietCnt_q == 9'd0 && alarm_q == AL_IDLE)
    else $error("quiet request did not start a clean quiet period");

  a_quiet_expiry: assert property (@(posedge clk) disable iff (rst)
    (tick && quietActive_q && !quietFall && quietCnt_q == 9'd367) |=> !quietActive_q && chirpLeft_q)
    else $error("quiet period did not end after 368 cycles");

  a_quiet_count: assert property (@(posedge clk) disable iff (rst)
    (tick && quietActive_q && !quietFall && quietCnt_q < 9'd367) |=> quietCnt_q == $past(quietCnt_q) + 9'd1)
    else $error("quiet timer disturbed");

  a_reduced_sens: assert property (@(posedge clk) disable iff (rst)
    !reducedSensOe_n |-> $past(quietActive_q && strobeCnt_q != '0))
    else $error("reduced sensitivity pulled outside a quiet strobe");

  a_remote_led: assert property (@(posedge clk) disable iff (rst)
    $past(alarm_q == AL_REMOTE) |-> !indicatorOn)
    else $error("indicator lit during remote alarm");

  a_local_ignore: assert property (@(posedge clk) disable iff (rst)
    alarm_q == AL_LOCAL |=> !pending_q)
    else $error("interconnect qualified during local alarm");

  a_qual_drop: assert property (@(posedge clk) disable iff (rst)
    (pending_q && !ioLvl) |=> !pending_q && alarm_q != AL_REMOTE)
    else $error("pending latch survived a low interconnect");

  a_io_delay: assert property (@(posedge clk) disable iff (rst)
    !interconnectOe_n |-> $past(alarm_q == AL_LOCAL && ioDelay_q == 7'd72))
    else $error("interconnect driven before the local delay");

  a_test_horn: assert property (@(posedge clk) disable iff (rst)
    (testMode_q && batLowLvl) |=> sounder_drive_a)
    else $error("test mode sounder not following low battery");

  a_batt_pulse: assert property (@(posedge clk) disable iff (rst)
    batteryCheck |-> $past(pulseCnt_q != '0 && batFlag_q && alarm_q == AL_IDLE))
    else $error("battery compared outside an idle indicator pulse");
endmodule

// File: aqis_defines.svh
`ifndef AQIS_DEFINES_SVH
`define AQIS_DEFINES_SVH

// ---------------------------------------------------------------
// time base
// ---------------------------------------------------------------
`define AQIS_CLK_MHZ 40
`define AQIS_SLOW_US 1670000
`define AQIS_FAST_US 41700
`define AQIS_STROBE_US 10000
`define AQIS_US2CYC(us) ((us) * `AQIS_CLK_MHZ)
`define AQIS_TICKS(us, per) (((us) + (per) / 2) / (per))

// ---------------------------------------------------------------
// sequence counts
// ---------------------------------------------------------------
`define AQIS_QUIET_TICKS 368
`define AQIS_BAT_TICKS 24
`define AQIS_QUAL_TICKS 2
`define AQIS_QUIET_LED_US 10000000
`define AQIS_ALARM_LED_US 1000000
`define AQIS_HORN_ON_US 160000
`define AQIS_HORN_OFF_US 80000
`define AQIS_IO_DELAY_US 3000000
`define AQIS_QUIET_LED_TICKS `AQIS_TICKS(`AQIS_QUIET_LED_US, `AQIS_SLOW_US)
`define AQIS_ALARM_LED_TICKS `AQIS_TICKS(`AQIS_ALARM_LED_US, `AQIS_FAST_US)
`define AQIS_HORN_ON_TICKS `AQIS_TICKS(`AQIS_HORN_ON_US, `AQIS_FAST_US)
`define AQIS_HORN_OFF_TICKS `AQIS_TICKS(`AQIS_HORN_OFF_US, `AQIS_FAST_US)
`define AQIS_IO_DELAY_TICKS `AQIS_TICKS(`AQIS_IO_DELAY_US, `AQIS_FAST_US)

// ---------------------------------------------------------------
// input synchroniser bit positions
// ---------------------------------------------------------------
`define AQIS_IN_SMOKE 0
`define AQIS_IN_BATLOW 1
`define AQIS_IN_QUIET 2
`define AQIS_IN_IO 3
`define AQIS_IN_CAP 4
`define AQIS_IN_SNDR 5
`define AQIS_IN_EXTOSC 6
`define AQIS_IN_WIDTH 7

`endif

// File: aqis_pkg.sv
package aqis_pkg;
  typedef enum logic [1:0] {
    AL_IDLE,
    AL_LOCAL,
    AL_REMOTE
  } aqis_alarm_t;
  typedef logic [26:0] aqis_cyc_t;
  typedef logic [18:0] aqis_strobe_t;
endpackage

// File: aqis_sync.sv
`timescale 1ns/100ps
module aqis_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds the second and nothing else
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= async;
      synced <= meta_q;
    end
  end
endmodule

// File: aqis_far_unit.sv
`timescale 1ns/100ps
module aqis_far_unit #(
  parameter int RESP_DLY = 3
) (
  input wire logic clk,
  input wire logic alarmCmd,
  output logic wireDrive = 1'b0
);
  int dlyCnt = 0;
  // ---------------------------------------------------------------
  // far alarm unit
  // ---------------------------------------------------------------
  // holds the wire high only while its own alarm lasts
  // a short command gives a noise burst that must be filtered
  // released wire falls to the pulldown level, never holds its last value
  always @(posedge clk) begin
    if (!alarmCmd) begin
      dlyCnt <= 0;
      wireDrive <= 1'b0;
    end else if (dlyCnt < RESP_DLY) begin
      dlyCnt <= dlyCnt + 1;
    end else begin
      wireDrive <= 1'b1;
    end
  end
endmodule

// File: alarm_quiet_interconnect_seq_bench.sv
`timescale 1ns/100ps
module alarm_quiet_interconnect_seq_bench;
  import aqis_pkg::*;
  localparam int SLOW = 200;
  localparam int FAST = 60;
  localparam int STB = 10;
  localparam int CAPP = 40;
  localparam int LIMIT = 70000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic smoke = 1'b0;
  logic batLow = 1'b0;
  logic quietReq = 1'b1;
  logic capDrv = 1'b1;
  logic capRun = 1'b0;
  logic fbPin = 1'b1;
  logic extOsc = 1'b0;
  logic farCmd = 1'b0;
  logic farDrive;
  logic ioWire;
  logic sounder_drive_a;
  logic indicatorOn;
  logic interconnectOut;
  logic interconnectOe_n;
  logic reducedSensOut;
  logic reducedSensOe_n;
  logic sensePower;
  logic batteryCheck;
  aqis_alarm_t alarmState;
  int errors = 0;
  int n_checks = 0;
  int cycCnt = 0;
  int tickCnt = 0;
  int capCnt = 0;
  // wire with pulldown: high only while some party drives it
  assign ioWire = farDrive | (!interconnectOe_n & interconnectOut);
  aqis_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .STROBE_CYC(STB)) i_dut (
    .clk(clk), .rst(rst), .smokeDetected(smoke), .batteryLow(batLow), .quietRequest(quietReq),
    .interconnectIn(ioWire), .timing_capacitor_node(capDrv), .sounder_in_a(fbPin), .extOscSelect(extOsc),
    .sounder_drive_a(sounder_drive_a), .indicatorOn(indicatorOn), .interconnectOut(interconnectOut),
    .interconnectOe_n(interconnectOe_n), .reducedSensOut(reducedSensOut), .reducedSensOe_n(reducedSensOe_n),
    .sensePower(sensePower), .batteryCheck(batteryCheck), .alarmState(alarmState)
  );
  aqis_far_unit #(.RESP_DLY(3)) i_far (.clk(clk), .alarmCmd(farCmd), .wireDrive(farDrive));
  always #12.5 clk = ~clk;
  // ---------------------------------------------------------------
  // accelerated tick source on the capacitor node
  // ---------------------------------------------------------------
  always begin
    @(posedge clk);
    #2;
    if (capRun) begin
      capCnt = (capCnt + 1) % (CAPP / 2);
      if (capCnt == 0) begin
        capDrv = ~capDrv;
        if (capDrv) begin
          tickCnt++;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycCnt++;
    if (cycCnt == LIMIT) begin
      errors++;
      give_verdict();
    end
  end
  task automatic check_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH %0t %s got %0d", $time, what, got);
    end
  endtask
  function automatic logic sig(input int which);
    case (which)
      0: return sensePower;
      1: return indicatorOn;
      2: return sounder_drive_a;
      3: return interconnectOe_n;
      4: return reducedSensOe_n;
      5: return alarmState === AL_LOCAL;
      6: return alarmState === AL_REMOTE;
      default: return alarmState === AL_IDLE;
    endcase
  endfunction
  // bounded wait; n is the number of cycles it took
  task automatic wait_until(input int which, input logic val, input int maxc, output int n);
    n = 0;
    while (sig(which) !== val && n < maxc) begin
      @(posedge clk);
      #2;
      n++;
    end
    check_bit(sig(which), val, "wait expired");
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_standby();
    int n;
    int m;
    check_bit(sig(7) & interconnectOe_n & reducedSensOe_n & !sounder_drive_a, 1'b1, "reset state");
    wait_until(0, 1'b1, SLOW * 2, n);
    wait_until(0, 1'b0, STB * 2, n);
    check_range(n, STB, STB, "strobe width");
    wait_until(0, 1'b1, SLOW, m);
    check_range(n + m, SLOW, SLOW, "standby period");
    wait_until(1, 1'b1, 24 * SLOW + 400, n);
    step(2);
    check_bit(batteryCheck, 1'b1, "battery check with led");
    wait_until(1, 1'b0, STB, n);
    batLow = 1'b1;
    wait_until(1, 1'b1, 24 * SLOW, m);
    check_range(n + m + 2, 24 * SLOW, 24 * SLOW, "led period");
    step(2);
    check_bit(sounder_drive_a, 1'b1, "low battery chirp");
    batLow = 1'b0;
  endtask
  task automatic t_local();
    int n;
    int t0;
    smoke = 1'b1;
    wait_until(5, 1'b1, SLOW * 2 + 50, n);
    t0 = cycCnt;
    farCmd = 1'b1;
    wait_until(2, 1'b1, 8 * FAST, n);
    // first on phase is cut short by the running slow count
    wait_until(2, 1'b0, 8 * FAST, n);
    wait_until(2, 1'b1, 8 * FAST, n);
    check_range(n, 2 * FAST, 2 * FAST, "horn off time");
    wait_until(2, 1'b0, 8 * FAST, n);
    check_range(n, 4 * FAST, 4 * FAST, "horn on time");
    wait_until(3, 1'b0, 80 * FAST, n);
    check_range(cycCnt - t0, 71 * FAST, 73 * FAST + STB, "io delay");
    check_bit(interconnectOut, 1'b1, "io driven high");
    check_bit(sig(5), 1'b1, "io ignored in local alarm");
    smoke = 1'b0;
    farCmd = 1'b0;
    wait_until(7, 1'b1, 12 * FAST, n);
    step(4 * FAST);
    check_bit(sig(7), 1'b1, "back to idle");
  endtask
  task automatic t_remote();
    int n;
    int m;
    int k;
    farCmd = 1'b1;
    // let any slow strobe finish so the next one is a fast tick
    step(8);
    wait_until(0, 1'b0, STB * 2, n);
    wait_until(0, 1'b1, SLOW + 50, n);
    wait_until(0, 1'b0, STB * 2, n);
    wait_until(0, 1'b1, SLOW, m);
    check_range(n + m, FAST, FAST, "fast period on io");
    wait_until(6, 1'b1, 4 * FAST, n);
    check_range(n, 0, FAST, "remote qualify time");
    k = 0;
    repeat (30 * FAST) begin
      step(1);
      if (indicatorOn !== 1'b0) begin
        k++;
      end
    end
    check_range(k, 0, 0, "led in remote alarm");
    farCmd = 1'b0;
    wait_until(7, 1'b1, 2 * SLOW, n);
    farCmd = 1'b1;
    // burst spans one tick so the latch is set and then dropped
    step(FAST + FAST / 2);
    farCmd = 1'b0;
    k = 0;
    repeat (5 * FAST) begin
      step(1);
      if (sig(7) !== 1'b1) begin
        k++;
      end
    end
    check_range(k, 0, 0, "glitch filtered");
  endtask
  task automatic t_quiet();
    int n;
    int k;
    int tq;
    logic ledPrev;
    extOsc = 1'b1;
    capRun = 1'b1;
    step(200);
    tq = tickCnt;
    quietReq = 1'b0;
    wait_until(4, 1'b0, 4 * CAPP, n);
    check_bit(sensePower, 1'b1, "pull low during strobe");
    check_bit(reducedSensOut, 1'b0, "pull level low");
    check_bit(sig(7), 1'b1, "quiet entry idle");
    smoke = 1'b1;
    wait_until(5, 1'b1, 8 * CAPP, n);
    smoke = 1'b0;
    wait_until(7, 1'b1, 20 * CAPP, n);
    k = 0;
    n = 0;
    ledPrev = 1'b0;
    while (sounder_drive_a !== 1'b1 && n < 380 * CAPP) begin
      step(1);
      n++;
      if (indicatorOn === 1'b1 && !ledPrev) begin
        k++;
      end
      ledPrev = indicatorOn;
    end
    check_range(tickCnt - tq, 366, 370, "quiet length");
    check_range(k, 56, 64, "quiet led count");
    wait_until(2, 1'b0, STB * 2, n);
    check_range(n, STB, STB, "chirp width");
    wait_until(2, 1'b1, CAPP * 2, k);
    check_range(n + k, CAPP, CAPP, "chirp spacing");
    wait_until(0, 1'b1, CAPP * 2, n);
    check_bit(reducedSensOe_n, 1'b1, "quiet ended");
    quietReq = 1'b1;
    capRun = 1'b0;
    extOsc = 1'b0;
  endtask
  task automatic t_testmode();
    capDrv = 1'b0;
    fbPin = 1'b0;
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    step(8);
    fbPin = 1'b1;
    batLow = 1'b1;
    step(4);
    check_bit(sounder_drive_a, 1'b1, "test mode low battery");
    batLow = 1'b0;
    step(4);
    check_bit(sounder_drive_a, 1'b0, "test mode battery ok");
  endtask
  initial begin
    step(20);
    rst = 1'b0;
    step(2);
    t_standby();
    t_local();
    t_remote();
    t_quiet();
    t_testmode();
    give_verdict();
  end
endmodule
